// ==== hw/video_stream_framing_monitor.sv ====
// stream buffer and framing monitor for the filter video ports

////////////////////////////////////////////////////////////////////////////
// synchronous fifo with valid/ready on both sides
module stream_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int PTR_W = $clog2(DEPTH);

  // depth must be a power of two for pointer wrap
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("stream_fifo depth must be a power of two");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];   // storage words
  logic [PTR_W:0] wr_ptr_reg;      // write pointer with wrap bit
  logic [PTR_W:0] rd_ptr_reg;      // read pointer with wrap bit
  wire full = (wr_ptr_reg[PTR_W] != rd_ptr_reg[PTR_W]) &&
              (wr_ptr_reg[PTR_W-1:0] == rd_ptr_reg[PTR_W-1:0]);
  wire empty = (wr_ptr_reg == rd_ptr_reg);
  wire do_wr = wr_valid_in && !full;
  wire do_rd = rd_ready_in && !empty;

  assign wr_ready_out = !full;
  assign rd_valid_out = !empty;
  assign rd_data_out = mem[rd_ptr_reg[PTR_W-1:0]];

  // pointer update; storage itself needs no reset
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

  // write port
  always_ff @(posedge sys_clk_in) begin
    if (do_wr) begin
      mem[wr_ptr_reg[PTR_W-1:0]] <= wr_data_in;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// framing monitor top
module video_stream_framing_monitor
  import framing_pkg::*;
#(
  parameter int INIT_LEN = INIT_CYCLES,
  parameter int FLUSH_LEN = FLUSH_CYCLES,
  parameter int BUF_DEPTH = FIFO_DEPTH
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // programmed active size
  input wire logic [SIZE_W-1:0] line_width_in,
  input wire logic [SIZE_W-1:0] frame_lines_in,
  // flush request, one-cycle pulse
  input wire logic flush_in,
  // per-bit clear of the error flags, one-cycle pulse
  input wire logic [ERR_FLAGS-1:0] err_clear_in,
  // input stream
  input wire logic [DATA_W-1:0] s_tdata_in,
  input wire logic s_tvalid_in,
  input wire logic s_tlast_in,
  input wire logic s_tuser_in,
  output logic s_tready_out,
  // output stream
  output logic [DATA_W-1:0] m_tdata_out,
  output logic m_tvalid_out,
  output logic m_tlast_out,
  output logic output_frame_start_marker_out,
  input wire logic m_tready_in,
  // error flags
  output logic [ERR_W-1:0] stream_framing_error_flags_out
);
  import framing_pkg::*;

  localparam int TMR_W = $clog2((INIT_LEN > FLUSH_LEN ? INIT_LEN :
                                 FLUSH_LEN) + 1);

  // refuse settings the logic cannot serve
  initial begin
    if (INIT_LEN < 1 || FLUSH_LEN < 1 || BUF_DEPTH < 2) begin
      $error("framing monitor parameters out of range");
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // declarations
  mon_state_t state_reg;          // hold-off state
  mon_state_t state_next;
  logic [TMR_W-1:0] tmr_reg;      // hold-off countdown
  logic [TMR_W-1:0] tmr_next;
  logic [SIZE_W-1:0] px_cnt_reg;  // pixels since last end-of-line
  logic [SIZE_W-1:0] ln_cnt_reg;  // lines since last start-of-frame
  logic seen_sof_reg;             // a frame start has been seen
  logic sof_pend_reg;             // next stored pixel opens the frame
  logic [ERR_FLAGS-1:0] err_reg;  // sticky error flags
  logic [ERR_FLAGS-1:0] err_set;  // events this cycle
  logic fifo_wr_ready;            // buffer has room
  logic fifo_rd_valid;            // buffer has a word
  logic [WORD_W-1:0] fifo_rd_word;

  //////////////////////////////////////////////////////////////////////////
  // decoding of the accepted beat

  wire running = (state_reg == ST_RUN);
  assign s_tready_out = running && fifo_wr_ready;
  wire beat = s_tvalid_in && s_tready_out;
  // a start marker restarts both counters
  wire [SIZE_W-1:0] px_pos = s_tuser_in ? '0 : px_cnt_reg;
  wire [SIZE_W-1:0] ln_pos = s_tuser_in ? '0 : ln_cnt_reg;
  wire [SIZE_W-1:0] px_pos_inc = px_pos + 1'b1;
  wire in_width = (px_pos < line_width_in);
  wire past_latency = (ln_pos >= SIZE_W'(LATENCY_LINES));
  wire store = beat && in_width && past_latency;
  // line end is the real marker or the width edge, whichever first
  wire word_eol = s_tlast_in || (px_pos_inc == line_width_in);
  wire word_sof = sof_pend_reg || s_tuser_in;
  wire [WORD_W-1:0] wr_word = {word_sof, word_eol, s_tdata_in};

  //////////////////////////////////////////////////////////////////////////
  // framing checks
  always_comb begin
    err_set = '0;
    if (beat && s_tlast_in && (px_pos_inc < line_width_in)) begin
      err_set[ERR_LINE_SHORT] = 1'b1;
    end
    if (beat && !in_width) begin
      err_set[ERR_LINE_LONG] = 1'b1;
    end
    if (beat && s_tuser_in && seen_sof_reg) begin
      if (ln_cnt_reg < frame_lines_in) begin
        err_set[ERR_FRAME_EARLY] = 1'b1;
      end else if (ln_cnt_reg > frame_lines_in) begin
        err_set[ERR_FRAME_LATE] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      err_reg <= ERR_RESET[ERR_FLAGS-1:0];
    end else begin
      err_reg <= (err_reg & ~err_clear_in) | err_set;
    end
  end

  assign stream_framing_error_flags_out = {{(ERR_W-ERR_FLAGS){1'b0}},
                                           err_reg};

  //////////////////////////////////////////////////////////////////////////
  // position counters
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || state_reg == ST_FLUSH) begin
      // a flush resynchronises to the next frame start
      px_cnt_reg <= '0;
      ln_cnt_reg <= '0;
      seen_sof_reg <= 1'b0;
      sof_pend_reg <= 1'b0;
    end else if (beat) begin
      if (s_tlast_in) begin
        px_cnt_reg <= '0;
        // saturate rather than wrap on runaway frames
        if (ln_pos != '1) begin
          ln_cnt_reg <= ln_pos + 1'b1;
        end else begin
          ln_cnt_reg <= ln_pos;
        end
      end else begin
        // counter saturates so long lines stay flagged
        if (px_pos != '1) begin
          px_cnt_reg <= px_pos_inc;
        end else begin
          px_cnt_reg <= px_pos;
        end
        ln_cnt_reg <= ln_pos;
      end
      if (s_tuser_in) begin
        seen_sof_reg <= 1'b1;
      end
      if (store) begin
        sof_pend_reg <= 1'b0;
      end else if (s_tuser_in) begin
        sof_pend_reg <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // hold-off state machine
  always_comb begin
    state_next = state_reg;
    tmr_next = tmr_reg;
    case (state_reg)
      ST_INIT, ST_FLUSH: begin
        if (tmr_reg == '0) begin
          state_next = ST_RUN;
        end else begin
          tmr_next = tmr_reg - 1'b1;
        end
      end
      default: begin
        if (flush_in) begin
          state_next = ST_FLUSH;
          tmr_next = TMR_W'(FLUSH_LEN - 1);
        end
      end
    endcase
  end

  // state and timer registers
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      state_reg <= ST_INIT;
      tmr_reg <= TMR_W'(INIT_LEN - 1);
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // buffer between input and output
  // downstream stall backs up
  stream_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(BUF_DEPTH)
  ) u_fifo (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .wr_data_in(wr_word),
    .wr_valid_in(store),
    .wr_ready_out(fifo_wr_ready),
    .rd_data_out(fifo_rd_word),
    .rd_valid_out(fifo_rd_valid),
    .rd_ready_in(m_tready_in)
  );

  // output fields straight from buffer storage flops
  assign m_tvalid_out = fifo_rd_valid;
  assign m_tdata_out = fifo_rd_word[DATA_W-1:0];
  assign m_tlast_out = fifo_rd_word[WORD_EOL];
  assign output_frame_start_marker_out = fifo_rd_word[WORD_SOF];
endmodule

// ==== hw/framing_pkg.sv ====
// shared constants for the video stream framing monitor
package framing_pkg;
  // pixel and size widths
  localparam int DATA_W = 24;
  localparam int SIZE_W = 13;
  // stream buffer depth in words
  localparam int FIFO_DEPTH = 32;
  // error flag register layout
  localparam int ERR_W = 32;
  localparam int ERR_LINE_SHORT = 0;
  localparam int ERR_LINE_LONG = 1;
  localparam int ERR_FRAME_EARLY = 2;
  localparam int ERR_FRAME_LATE = 3;
  localparam int ERR_FLAGS = 4;
  localparam logic [ERR_W-1:0] ERR_RESET = 32'h0000_0000;
  // lines absorbed before output starts
  localparam int LATENCY_LINES = 2;
  // hold-off periods in clock cycles
  localparam int INIT_CYCLES = 16;
  localparam int FLUSH_CYCLES = 8;
  // word layout inside the buffer: {sof, eol, pixel}
  localparam int WORD_W = DATA_W + 2;
  localparam int WORD_EOL = DATA_W;
  localparam int WORD_SOF = DATA_W + 1;
  // monitor states
  typedef enum logic [1:0] {
    ST_INIT,
    ST_RUN,
    ST_FLUSH
  } mon_state_t;
endpackage

// ==== bench/framing_checker.sv ====
// port assertions for the video stream framing monitor
module framing_checker
  import framing_pkg::*;
#(parameter int INIT_LEN = 16, parameter int FLUSH_LEN = 8) (
  input wire logic sys_clk_in, rstn_in, flush_in, s_tvalid_in,
  input wire logic s_tlast_in, s_tuser_in, s_tready_out,
  input wire logic m_tvalid_out, m_tready_in, m_tlast_out,
  input wire logic [SIZE_W-1:0] line_width_in,
  input wire logic [DATA_W-1:0] m_tdata_out,
  input wire logic [ERR_FLAGS-1:0] err_clear_in,
  input wire logic [ERR_W-1:0] stream_framing_error_flags_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  localparam int RISE_MAX = INIT_LEN + 2;
  logic [SIZE_W-1:0] idx_reg; // index of the next pixel in its line
  int up_reg, hold_reg, lines_reg; // cycles up, flush hold, lines in
  wire beat = s_tvalid_in && s_tready_out;
  wire [SIZE_W-1:0] idx = s_tuser_in ? '0 : idx_reg;
  wire [3:0] fl = stream_framing_error_flags_out[3:0];
  // helper counters; line count saturates at two since only that matters
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      up_reg <= 0;
      hold_reg <= 0;
      lines_reg <= 0;
      idx_reg <= '0;
    end else begin
      up_reg <= up_reg + (up_reg < 1000);
      hold_reg <= beat ? 0 : hold_reg;
      if (flush_in && s_tready_out)
        hold_reg <= FLUSH_LEN;
      else if (hold_reg > 0)
        hold_reg <= hold_reg - 1;
      lines_reg <= lines_reg + (beat && s_tlast_in && lines_reg < 2);
      if (flush_in)
        idx_reg <= '0;
      else if (beat)
        idx_reg <= s_tlast_in ? '0 : idx + 1'b1;
    end
  end
  a_init_hold: assert property (
    s_tready_out |-> up_reg >= INIT_LEN - 1) else $error("ready in init");
  a_ready_back: assert property (
    $rose(rstn_in) |-> ##[1:RISE_MAX] s_tready_out) else $error("no ready");
  a_flush_hold: assert property (
    hold_reg != 0 |-> !s_tready_out) else $error("ready in flush");
  a_out_hold: assert property (
    m_tvalid_out && !m_tready_in |=> m_tvalid_out && $stable(m_tdata_out)
    && $stable(m_tlast_out)) else $error("output moved while stalled");
  a_first_lines: assert property (
    m_tvalid_out |-> lines_reg == 2) else $error("early output");
  a_short_line: assert property (
    beat && s_tlast_in && idx + 1 < line_width_in |=> fl[0])
    else $error("short line missed");
  a_long_line: assert property (
    beat && idx >= line_width_in |=> fl[1]) else $error("long line missed");
  a_flags_stick: assert property (
    1'b1 |=> ($past(fl) & ~$past(err_clear_in) & ~fl) == 4'h0)
    else $error("flag lost");
  a_frame_cause: assert property (
    $rose(fl[2]) || $rose(fl[3]) |-> $past(s_tuser_in) && $past(beat))
    else $error("frame flag without start");
endmodule

bind video_stream_framing_monitor framing_checker #(.INIT_LEN(INIT_LEN),
  .FLUSH_LEN(FLUSH_LEN)) framing_checker_i (.sys_clk_in(sys_clk_in),
  .rstn_in(rstn_in), .flush_in(flush_in), .s_tvalid_in(s_tvalid_in),
  .s_tlast_in(s_tlast_in), .s_tuser_in(s_tuser_in),
  .s_tready_out(s_tready_out), .m_tvalid_out(m_tvalid_out),
  .m_tready_in(m_tready_in), .m_tlast_out(m_tlast_out),
  .line_width_in(line_width_in), .m_tdata_out(m_tdata_out),
  .err_clear_in(err_clear_in),
  .stream_framing_error_flags_out(stream_framing_error_flags_out));

// ==== bench/sink_model.sv ====
// downstream consumer on the same clock, stalls on command
module sink_model (
  input wire logic sys_clk_in,
  input wire logic stall_in,
  output logic m_tready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph_reg = 3'h0; // phase of the slow-ready pattern
  initial m_tready_out = 1'b0;
  // ready low while stalled, and one cycle in eight otherwise
  always @(negedge sys_clk_in) begin
    ph_reg <= ph_reg + 3'h1;
    m_tready_out <= !stall_in && ph_reg != 3'h2;
  end
endmodule

// ==== bench/video_stream_framing_monitor_bench.sv ====
// self-checking bench for the video stream framing monitor
module video_stream_framing_monitor_bench import framing_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, flush = 0, valid = 0, last = 0, user = 0;
  logic stall = 0, ready, ovalid, olast, osof, oready;
  logic [SIZE_W-1:0] width = 13'h4, lines = 13'h3;
  logic [ERR_FLAGS-1:0] clr = 4'h0;
  logic [DATA_W-1:0] data = '0, odata;
  logic [ERR_W-1:0] flags, exp_flags = '0;
  logic [WORD_W-1:0] expq[$]; // expected {sof, eol, pixel} words
  int mismatches = 0, checks_done = 0, pix = 0, ln = 0, seen = 0, psof = 0;
  int unsigned seed = 56;
  video_stream_framing_monitor #(.INIT_LEN(4), .FLUSH_LEN(4))
    video_stream_framing_monitor_i (.sys_clk_in(clk), .rstn_in(rstn),
    .line_width_in(width), .frame_lines_in(lines), .flush_in(flush),
    .err_clear_in(clr), .s_tdata_in(data), .s_tvalid_in(valid),
    .s_tlast_in(last), .s_tuser_in(user), .s_tready_out(ready),
    .m_tdata_out(odata), .m_tvalid_out(ovalid), .m_tlast_out(olast),
    .output_frame_start_marker_out(osof), .m_tready_in(oready),
    .stream_framing_error_flags_out(flags));
  sink_model sink_model_i (.sys_clk_in(clk), .stall_in(stall),
    .m_tready_out(oready));
  initial forever #2 clk = ~clk;
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // offers one beat, holds it until taken, then steps the model
  // source runs on the device clock, so no async buffer needed
  task automatic send(input logic l, u);
    @(negedge clk);
    data = DATA_W'(rnd());
    last = l;
    user = u;
    valid = 1;
    do @(posedge clk); while (ready !== 1'b1);
    // frame length judged at each start marker after the first
    if (u) begin
      exp_flags[2] |= seen && ln < lines;
      exp_flags[3] |= seen && ln > lines;
      seen = 1;
      pix = 0;
      ln = 0;
      psof = 1;
    end
    // pixels past the width are dropped
    if (pix >= width)
      exp_flags[1] = 1;
    else if (ln >= 2) begin
      expq.push_back({psof[0], l || pix == width - 1, data});
      psof = 0;
    end
    // short line judged at its end marker
    exp_flags[0] |= l && pix + 1 < width;
    pix = l ? 0 : pix + 1;
    ln += l;
  endtask
  task automatic line(input int n, input logic u);
    for (int i = 0; i < n; i++)
      send(i == n - 1, u && i == 0);
    @(negedge clk) valid = 0;
  endtask
  task automatic flags_check();
    repeat (2) @(negedge clk);
    check(flags, exp_flags);
  endtask
  // every word taken downstream must match the model queue
  always @(posedge clk)
    if (rstn && ovalid === 1'b1 && oready)
      check({osof, olast, odata}, expq.size() ? expq.pop_front() : '1);
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    complete_run();
  end
  initial begin
    repeat (4) @(negedge clk);
    rstn = 1;
    repeat (2) @(negedge clk);
    check(ready, 0);
    repeat (4) @(negedge clk);
    check(ready, 1);
    // normal, short, long, normal line, then two frame-size errors
    line(4, 1);
    line(3, 0);
    line(6, 0);
    line(4, 0);
    line(4, 1);
    line(4, 0);
    line(4, 1);
    flags_check();
    @(negedge clk) clr = 4'h5;
    @(negedge clk) clr = 4'h0;
    exp_flags[2] = 0;
    exp_flags[0] = 0;
    flags_check();
    // stall the consumer until the buffer refuses input, then drain
    width = 13'h30;
    stall = 1;
    line(1, 1);
    line(1, 0);
    fork
      line(40, 0);
      begin
        repeat (100) @(negedge clk);
        check(ready, 0);
        stall = 0;
      end
    join
    repeat (40) @(negedge clk);
    @(negedge clk) flush = 1;
    @(negedge clk) flush = 0;
    check(ready, 0);
    seen = 0;
    ln = 0;
    pix = 0;
    repeat (6) @(negedge clk);
    check(ready, 1);
    line(4, 1);
    flags_check();
    repeat (80) @(negedge clk);
    check(expq.size(), 0);
    check(ovalid, 0);
    complete_run();
  end
endmodule
